//--- design/fbl_loader.v
// Flash bitstream loader: host bit port, flash program and passive serial load.
// Assumes a 50 MHz mclk, async host pins and an external open-drain resolver.
`timescale 1ns/1ps
`default_nettype none
`include "fbl_regs.vh"
module fbl_loader (
    // Clock and reset.
    input  wire        mclk,
    input  wire        reset,
    // Host bit port.
    input  wire        host_bit_strobe,
    input  wire        host_cmd_select,
    input  wire        host_bit,
    output reg         host_ack,
    output reg         load_status,
    // Flash memory.
    output reg  [15:0] flash_addr,
    input  wire [7:0]  flash_rd_data,
    output reg  [7:0]  flash_wr_data,
    output reg         flash_ce_n,
    output reg         flash_oe_n,
    output reg         flash_we_n,
    output reg         flash_wr_data_oe,
    // Target passive serial pins.
    output reg         cfg_clk,
    output reg         serial_cfg_bit,
    output reg         target_cfg_n,
    input  wire        target_error_n,
    output wire        target_error_n_out,
    output wire        target_error_n_oe,
    input  wire        target_done,
    output wire        target_done_out,
    output wire        target_done_oe,
    input  wire        target_init_done,
    output wire        target_init_done_out,
    output wire        target_init_done_oe
);
    localparam M_CHECK = 4'h0, M_CHECK2 = 4'h1, M_IDLE = 4'h2, M_ERASE = 4'h3;
    localparam M_PROG = 4'h4, M_MARK = 4'h5, M_CFGLOW = 4'h6, M_CF2CK = 4'h7;
    localparam M_SHIFT = 4'h8, M_INIT = 4'h9, M_DONE = 4'ha;
    localparam W_IDLE = 2'h0, W_SETUP = 2'h1, W_PULSE = 2'h2, W_HOLD = 2'h3;

    function [2:0] sync_push;
        input [2:0] s;
        input       pin;
        begin
            sync_push = {s[1:0], pin};
        end
    endfunction

    reg [2:0]  stb_s, sel_s, bit_s, err_s, done_s;
    reg        stb_lvl, err_lvl, done_lvl;
    reg [3:0]  state;
    reg [1:0]  wstate;
    reg [3:0]  wcnt;
    reg        wreq;
    reg [15:0] wcount;
    reg [2:0]  div;
    reg [2:0]  bitn;
    reg [7:0]  shreg;
    reg [1:0]  cmd;
    reg        cmd_seen;
    reg        ack_pend;
    wire       div_en;
    wire       new_bit;
    wire       fifo_ready, fifo_valid;
    wire [7:0] fifo_out;
    wire       fifo_take;
    wire       fifo_push;

    assign div_en  = (div == `FBL_DIV_LAST);
    // A change counts once the second and third stages agree.
    assign new_bit = (stb_s[1] == stb_s[2]) && (stb_s[2] != stb_lvl);
    assign fifo_push = new_bit && !sel_s[2] && (bitn == 3'h7) && (state == M_PROG);
    assign fifo_take = fifo_valid && (wstate == W_IDLE) && (state == M_PROG) && !wreq;
    // Open-drain status lines are only ever released by the loader.
    assign target_error_n_out   = 1'b0;
    assign target_error_n_oe    = 1'b0;
    assign target_done_out      = 1'b0;
    assign target_done_oe       = 1'b0;
    assign target_init_done_out = 1'b0;
    assign target_init_done_oe  = 1'b0;

    fbl_fifo #(.WIDTH(8), .DEPTH(`FBL_FIFO_DEPTH), .AW(`FBL_FIFO_AW)) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_data   ({bit_s[2], shreg[7:1]}),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    always @(posedge mclk) begin
        if (reset) begin
            stb_s <= 3'h0; sel_s <= 3'h0; bit_s <= 3'h0; err_s <= 3'h7; done_s <= 3'h0;
        end else begin
            stb_s  <= sync_push(stb_s, host_bit_strobe);
            sel_s  <= sync_push(sel_s, host_cmd_select);
            bit_s  <= sync_push(bit_s, host_bit);
            err_s  <= sync_push(err_s, target_error_n);
            done_s <= sync_push(done_s, target_done);
        end
    end

    // Flash write sub-machine: setup, timed write pulse, hold.
    always @(posedge mclk) begin
        if (reset) begin
            wstate <= W_IDLE;
            wcnt   <= 4'h0;
            flash_we_n <= 1'b1;
            flash_wr_data_oe <= 1'b0;
        end else begin
            case (wstate)
                W_IDLE: begin
                    if (wreq) begin
                        wstate <= W_SETUP;
                        flash_wr_data_oe <= 1'b1;
                    end
                end
                W_SETUP: begin
                    wstate <= W_PULSE;
                    flash_we_n <= 1'b0;
                    wcnt <= `FBL_PULSE_CYC;
                end
                W_PULSE: begin
                    wcnt <= wcnt - 4'h1;
                    if (wcnt == 4'h1) begin
                        flash_we_n <= 1'b1;
                        wstate <= W_HOLD;
                    end
                end
                W_HOLD: begin
                    flash_wr_data_oe <= 1'b0;
                    wstate <= W_IDLE;
                end
                default: wstate <= W_IDLE;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            state <= M_CHECK; div <= 3'h0; wcount <= 16'h0; bitn <= 3'h0;
            shreg <= 8'h0; cmd <= 2'h0; cmd_seen <= 1'b0; stb_lvl <= 1'b0;
            err_lvl <= 1'b1; done_lvl <= 1'b0;
            host_ack <= 1'b0; load_status <= 1'b0; ack_pend <= 1'b0;
            flash_addr <= `FBL_MARKER_ADDR; flash_wr_data <= 8'h0; flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1; cfg_clk <= 1'b0; serial_cfg_bit <= 1'b0;
            target_cfg_n <= 1'b1; wreq <= 1'b0;
        end else begin
            div  <= div + 3'h1;
            wreq <= 1'b0;
            if ((err_s[1] == err_s[2])) err_lvl <= err_s[2];
            if ((done_s[1] == done_s[2])) done_lvl <= done_s[2];
            if (new_bit) begin
                stb_lvl <= stb_s[2];
                shreg <= {bit_s[2], shreg[7:1]};
                bitn  <= bitn + 3'h1;
                ack_pend <= 1'b1;
            end
            // Ack waits for FIFO room and for the erase to end, so no data bit is lost.
            if (ack_pend && fifo_ready && !new_bit && state != M_ERASE) begin
                host_ack <= stb_lvl;
                ack_pend <= 1'b0;
            end
            case (state)
                M_CHECK: begin
                    // A load cut short by an error may leave the clock high.
                    cfg_clk <= 1'b0;
                    serial_cfg_bit <= 1'b0;
                    flash_addr <= `FBL_MARKER_ADDR;
                    flash_ce_n <= 1'b0;
                    flash_oe_n <= 1'b0;
                    state <= M_CHECK2;
                end
                M_CHECK2: begin
                    flash_oe_n <= 1'b1;
                    flash_ce_n <= 1'b1;
                    wcount <= 16'h0;
                    state <= (flash_rd_data == `FBL_MARKER_BYTE) ? M_CFGLOW : M_IDLE;
                end
                M_IDLE: begin
                    // Chip enable stays low until the marker write has finished.
                    if (wstate == W_IDLE && !wreq) flash_ce_n <= 1'b1;
                    if (new_bit && sel_s[2]) begin
                        cmd <= {bit_s[2], cmd[1]};
                        cmd_seen <= ~cmd_seen;
                        if (cmd_seen) begin
                            bitn <= 3'h0;
                            wcount <= 16'h0;
                            if ({bit_s[2], cmd[1]} == `FBL_CMD_PROG) state <= M_ERASE;
                            else if ({bit_s[2], cmd[1]} == `FBL_CMD_LOAD) state <= M_CFGLOW;
                        end
                    end else if (new_bit) begin
                        bitn <= 3'h0;
                    end
                end
                M_ERASE: begin
                    flash_ce_n <= 1'b0;
                    wcount <= wcount + 16'h1;
                    if (wcount == `FBL_ERASE_CYC) begin
                        flash_addr <= 16'h0;
                        state <= M_PROG;
                    end
                end
                M_PROG: begin
                    if (fifo_take) begin
                        flash_wr_data <= fifo_out;
                        wreq <= 1'b1;
                    end
                    if (wstate == W_HOLD) flash_addr <= flash_addr + 16'h1;
                    if (new_bit && sel_s[2] && !fifo_valid && wstate == W_IDLE) begin
                        state <= M_MARK;
                    end
                end
                M_MARK: begin
                    if (wstate == W_IDLE && !wreq) begin
                        flash_addr <= `FBL_MARKER_ADDR;
                        flash_wr_data <= `FBL_MARKER_BYTE;
                        wreq <= 1'b1;
                        state <= M_IDLE;
                        cmd_seen <= 1'b0;
                    end
                end
                M_CFGLOW: begin
                    target_cfg_n <= 1'b0;
                    load_status <= 1'b0;
                    flash_ce_n <= 1'b1;
                    if (div_en) begin
                        wcount <= wcount + 16'h1;
                        if (wcount == `FBL_CFG_LOW_CYC) begin
                            wcount <= 16'h0;
                            target_cfg_n <= 1'b1;
                            state <= M_CF2CK;
                        end
                    end
                end
                M_CF2CK: begin
                    if (div_en) begin
                        wcount <= wcount + 16'h1;
                        if (wcount == `FBL_CF2CK_CYC) begin
                            wcount <= 16'h0;
                            bitn <= 3'h0;
                            flash_addr <= 16'h0;
                            flash_ce_n <= 1'b0;
                            flash_oe_n <= 1'b0;
                            state <= M_SHIFT;
                        end
                    end
                end
                M_SHIFT: begin
                    // Data changes while cfg_clk is low, rising edge mid-period.
                    if (div == 3'h0) serial_cfg_bit <= flash_rd_data[bitn];
                    if (div == 3'h3) cfg_clk <= 1'b1;
                    if (div_en) begin
                        cfg_clk <= 1'b0;
                        bitn <= bitn + 3'h1;
                        if (bitn == 3'h7) flash_addr <= flash_addr + 16'h1;
                        if (done_lvl) begin
                            wcount <= wcount + 16'h1;
                            if (wcount == `FBL_INIT_EXTRA) state <= M_INIT;
                        end
                    end
                end
                M_INIT: begin
                    cfg_clk <= 1'b0;
                    serial_cfg_bit <= 1'b0;
                    flash_ce_n <= 1'b1;
                    flash_oe_n <= 1'b1;
                    load_status <= 1'b1;
                    cmd_seen <= 1'b0;
                    state <= M_DONE;
                end
                M_DONE: begin
                    if (!err_lvl) begin
                        wcount <= 16'h0;
                        load_status <= 1'b0;
                        state <= M_CHECK;
                    end else if (new_bit && sel_s[2]) begin
                        state <= M_IDLE;
                        cmd <= {bit_s[2], cmd[1]};
                        cmd_seen <= 1'b1;
                    end
                end
                default: state <= M_CHECK;
            endcase
            if (!err_lvl && state == M_SHIFT) state <= M_CHECK;
        end
    end
endmodule // fbl_loader
`default_nettype wire

//--- design/fbl_regs.vh
// Constants for the flash bitstream loader: marker, timing counts, command codes.
// Assumes a 50 MHz mclk; included by the loader and its FIFO.
`ifndef FBL_REGS_VH
`define FBL_REGS_VH
`define FBL_MARKER_ADDR   16'hffff
`define FBL_MARKER_BYTE   8'ha5
`define FBL_ADDR_W        16
`define FBL_CLK_MHZ       50
`define FBL_DIV_W         3
`define FBL_DIV_LAST      3'h7
`define FBL_CFG_LOW_US    8
`define FBL_CFG_LOW_CYC   ((`FBL_CFG_LOW_US * `FBL_CLK_MHZ + 7) / 8)
`define FBL_CF2CK_US      40
`define FBL_CF2CK_CYC     ((`FBL_CF2CK_US * `FBL_CLK_MHZ + 7) / 8)
`define FBL_INIT_EXTRA    40
`define FBL_ERASE_CYC     16'h0400
`define FBL_PULSE_CYC     4'h4
`define FBL_FIFO_DEPTH    16
`define FBL_FIFO_AW       4
`define FBL_CMD_PROG      2'h1
`define FBL_CMD_LOAD      2'h2
`endif

//--- design/fbl_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "fbl_regs.vh"
module fbl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `FBL_FIFO_DEPTH,
    parameter AW    = `FBL_FIFO_AW
) (
    // Clock and reset.
    input  wire             mclk,
    input  wire             reset,
    // Fill side.
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side.
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;
    assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty     = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    always @(posedge mclk) begin
        if (in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // fbl_fifo
`default_nettype wire

//--- test/fbl_loader_properties.sv
// Checker for the loader's host handshake, flash strobes and serial load pins.
// Assumes a bind to fbl_loader and a 50 MHz mclk.
`timescale 1ns/1ps
`default_nettype none
module fbl_loader_properties (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Host, flash and target pins.
    input wire logic host_bit_strobe,
    input wire logic host_ack,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_wr_data_oe,
    input wire logic cfg_clk,
    input wire logic serial_cfg_bit,
    input wire logic target_cfg_n
);
    // Cycles of mclk for 8 us and 40 us.
    localparam int LOW_MIN  = 400;
    localparam int WAIT_MIN = 2000;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    // The counts saturate, so a long idle spell cannot wrap into a false failure.
    always_ff @(posedge mclk) begin
        low_cnt  <= (reset || target_cfg_n) ? 16'h0 : low_cnt + {15'h0, ~&low_cnt};
        high_cnt <= (reset || !target_cfg_n) ? 16'h0 : high_cnt + {15'h0, ~&high_cnt};
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    property p_ack_level;
        $changed(host_ack) |-> host_ack == host_bit_strobe;
    endproperty
    a_ack_level: assert property (p_ack_level) else $error("ack differs from strobe");
    property p_cfg_low;
        $rose(target_cfg_n) |-> low_cnt >= LOW_MIN;
    endproperty
    a_cfg_low: assert property (p_cfg_low) else $error("reconfigure pulse short");
    property p_first_clk;
        $rose(cfg_clk) |-> high_cnt >= WAIT_MIN;
    endproperty
    a_first_clk: assert property (p_first_clk) else $error("cfg_clk too early");
    property p_clk_period;
        $rose(cfg_clk) |=> (!$rose(cfg_clk)) [*7];
    endproperty
    a_clk_period: assert property (p_clk_period) else $error("cfg_clk too fast");
    property p_bit_stable;
        $rose(cfg_clk) |-> $stable(serial_cfg_bit);
    endproperty
    a_bit_stable: assert property (p_bit_stable) else $error("bit moved at clock");
    property p_idle_clk;
        !target_cfg_n |-> !cfg_clk;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("cfg_clk in reconfigure");
    property p_we_qual;
        !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_wr_data_oe;
    endproperty
    a_we_qual: assert property (p_we_qual) else $error("bad write strobes");
    property p_we_pulse;
        $fell(flash_we_n) |-> (!flash_we_n) [*4] ##1 flash_we_n;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse width");
endmodule // fbl_loader_properties
bind fbl_loader fbl_loader_properties u_fbl_loader_properties (
    .mclk(mclk), .reset(reset), .host_bit_strobe(host_bit_strobe), .host_ack(host_ack),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_wr_data_oe(flash_wr_data_oe), .cfg_clk(cfg_clk), .serial_cfg_bit(serial_cfg_bit),
    .target_cfg_n(target_cfg_n)
);
`default_nettype wire

//--- test/fbl_far_model.sv
// Far side: a parallel flash array and one passive serial target.
// Assumes writes are sampled on mclk while flash_we_n is low.
`timescale 1ns/1ps
`default_nettype none
module fbl_far_model #(
    parameter int DONE_BITS = 64
) (
    // Clock.
    input  wire logic        mclk,
    // Flash pins.
    input  wire logic [15:0] flash_addr,
    input  wire logic [7:0]  flash_wr_data,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_wr_data_oe,
    output var  logic [7:0]  flash_rd_data,
    // Target pins.
    input  wire logic        cfg_clk,
    input  wire logic        serial_cfg_bit,
    input  wire logic        target_cfg_n,
    output var  logic        model_done,
    output var  int          bit_cnt,
    output var  int          bit_errs
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_rd = 8'h0;
    // A blank part reads all ones, so no marker is seen at first.
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
        model_done = 1'b0;
        bit_cnt = 0;
        bit_errs = 0;
    end
    // A released bus shows the inverse of its last value, never a held copy.
    assign flash_rd_data = (!flash_ce_n && !flash_oe_n) ? mem[flash_addr] : ~last_rd;
    always @(posedge mclk) begin
        if (!flash_ce_n && !flash_oe_n) last_rd <= mem[flash_addr];
        if (!flash_ce_n && !flash_we_n) mem[flash_addr] <= flash_wr_data;
    end
    // Each reconfigure request restarts the target's bit count.
    always @(posedge cfg_clk or negedge target_cfg_n) begin
        if (!target_cfg_n) begin
            bit_cnt <= 0;
            model_done <= 1'b0;
        end else begin
            if (serial_cfg_bit !== mem[bit_cnt / 8][bit_cnt % 8]) bit_errs <= bit_errs + 1;
            bit_cnt <= bit_cnt + 1;
            if (bit_cnt == DONE_BITS - 1) model_done <= 1'b1;
        end
    end
endmodule // fbl_far_model
`default_nettype wire

//--- test/fbl_loader_tb.sv
// Self-checking bench for the flash bitstream loader.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fbl_regs.vh"
module fbl_loader_tb;
    logic mclk = 1'b0, reset = 1'b1, strobe = 1'b0, sel = 1'b0, hbit = 1'b0, err_n = 1'b1;
    logic host_ack, load_status, ce_n, oe_n, we_n, wd_oe, cfg_clk, sbit, cfg_n, mdone;
    logic e_out, e_oe, d_out, d_oe, i_out, i_oe;
    logic last_ack = 1'b0;
    logic [15:0] addr;
    logic [7:0] rd, wd;
    logic [7:0] data [0:23];
    logic exp_q [$];
    int n_errors = 0, total_checks = 0, max_wait = 0, bit_cnt, bit_errs;
    // Open-drain lines: any party pulling low wins over the pull-up.
    wire err_w = err_n & ~(e_oe & ~e_out);
    wire done_w = mdone & ~(d_oe & ~d_out);
    wire init_w = done_w & ~(i_oe & ~i_out);
    always #10 mclk = ~mclk;
    fbl_loader u_fbl_loader (.mclk(mclk), .reset(reset), .host_bit_strobe(strobe),
        .host_cmd_select(sel), .host_bit(hbit), .host_ack(host_ack), .load_status(load_status),
        .flash_addr(addr), .flash_rd_data(rd), .flash_wr_data(wd), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_wr_data_oe(wd_oe), .cfg_clk(cfg_clk),
        .serial_cfg_bit(sbit), .target_cfg_n(cfg_n), .target_error_n(err_w),
        .target_error_n_out(e_out), .target_error_n_oe(e_oe), .target_done(done_w),
        .target_done_out(d_out), .target_done_oe(d_oe), .target_init_done(init_w),
        .target_init_done_out(i_out), .target_init_done_oe(i_oe));
    fbl_far_model #(.DONE_BITS(64)) u_fbl_far_model (.mclk(mclk), .flash_addr(addr),
        .flash_wr_data(wd), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_wr_data_oe(wd_oe), .flash_rd_data(rd), .cfg_clk(cfg_clk), .serial_cfg_bit(sbit),
        .target_cfg_n(cfg_n), .model_done(mdone), .bit_cnt(bit_cnt), .bit_errs(bit_errs));
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The host holds select and bit one cycle ahead of its strobe edge.
    task automatic send_bit(input logic s, input logic b);
        int w;
        @(posedge mclk);
        sel <= s;
        hbit <= b;
        @(posedge mclk);
        strobe <= ~strobe;
        exp_q.push_back(~strobe);
        w = 0;
        @(posedge mclk);
        while (host_ack !== strobe && w < 3000) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 3000) begin
            n_errors++;
            test_done();
        end
        if (w > max_wait) max_wait = w;
    endtask
    task automatic send_cmd(input logic [1:0] c);
        for (int i = 0; i < 2; i++) send_bit(1'b1, c[i]);
    endtask
    task automatic send_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) send_bit(1'b0, d[i]);
    endtask
    task automatic wait_for(input int which, input int lim);
        int w;
        w = 0;
        while (!((which == 0 && load_status === 1'b1) || (which == 1 && cfg_n === 1'b0)
                || (which == 2 && mdone === 1'b1)) && w < lim) begin
            @(posedge mclk);
            w++;
        end
        if (w >= lim) begin
            n_errors++;
            test_done();
        end
    endtask
    always @(posedge mclk) begin
        if (!reset && host_ack !== last_ack) begin
            if (exp_q.size() == 0)
                check(host_ack, ~host_ack, "spare host_ack");
            else
                check(host_ack, exp_q.pop_front(), "host_ack");
        end
        last_ack <= host_ack;
    end
    initial begin
        void'($urandom(20639));
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (100) @(posedge mclk);
        check(cfg_n, 1'b1, "cfg_n blank");
        check(load_status, 1'b0, "status blank");
        $display("Test blank_idle done");
        send_cmd(`FBL_CMD_PROG);
        for (int i = 0; i < 24; i++) begin
            data[i] = 8'($urandom);
            send_byte(data[i]);
        end
        check(max_wait > 20, 1'b1, "ack stall");
        repeat (300) @(posedge mclk);
        send_bit(1'b1, 1'b0);
        repeat (100) @(posedge mclk);
        for (int i = 0; i < 24; i++) check(u_fbl_far_model.mem[i], data[i], "flash");
        check(u_fbl_far_model.mem[16'hffff], `FBL_MARKER_BYTE, "marker");
        $display("Test program done");
        send_cmd(`FBL_CMD_LOAD);
        wait_for(0, 20000);
        check(16'(bit_errs), 16'h0, "serial bits");
        $display("Test load_cmd done");
        strobe <= 1'b0;
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check(load_status, 1'b0, "status reset");
        wait_for(0, 20000);
        err_n <= 1'b0;
        wait_for(1, 200);
        err_n <= 1'b1;
        wait_for(2, 20000);
        check(16'(bit_errs), 16'h0, "serial bits again");
        $display("Test power_up_restart done");
        test_done();
    end
endmodule // fbl_loader_tb
`default_nettype wire
